// ### arph_pkg.sv
// arph_pkg: constants, register map and control field layout of the
// converter result path (result split, display source, peak/hold).
// assumes a deframed host register port and a filter that delivers
// one auto-calibrated 20-bit result per conversion as a pulse.
package arph_pkg;

    // register port and result geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int RAW_W = 20;
    localparam int LOW_W = 4;

    // register indices on the host register port
    localparam logic [ADDR_W-1:0] IDX_RESULT_UPPER = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_DISPLAY = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_PEAK = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_RESULT_LOW = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] IDX_CUSTOM_OFFSET = 4'h6;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // control register field positions
    localparam int CTL_SRC_HOST = 0;
    localparam int CTL_PEAK = 1;
    localparam int CTL_HOLD = 2;
    localparam int CTL_CONT_OFFSET_DIS = 3;
    localparam int CTL_ENH_OFFSET_TRIG = 4;
    localparam int CTL_DIG_PD = 5;
    localparam int CTL_ANA_PD = 6;
    localparam int CTL_RANGE = 7;

    // status register field positions
    localparam int STS_UNDERVOLTAGE = 0;
    localparam int STS_PEAK_ACTIVE = 1;
    localparam int STS_HOLD_ACTIVE = 2;
    localparam int STS_ENH_BUSY = 3;
    localparam int STS_VARIANT_45 = 4;

    // position of the low result nibble inside its 8-bit register
    localparam int LOW_NIBBLE_POS = 4;

    // signed compare of two 16-bit two's complement words
    function automatic logic signed_gt(input logic [15:0] a, input logic [15:0] b);
        signed_gt = $signed(a) > $signed(b);
    endfunction : signed_gt

endpackage : arph_pkg

// ### arph_peak_track.sv
// arph_peak_track: peak register with seed on enable, signed compare
// and clear on a write of zero to the peak enable bit.
// assumes sample_valid_i is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module arph_peak_track
    import arph_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic peak_en_i,
    input wire logic peak_clr_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i,
    input wire logic [15:0] current_i,
    output logic [15:0] peak_o
);

    logic en_d;

    // remembers the enable of the previous cycle to find its rising edge
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_d <= 1'b0;
        end else begin
            en_d <= peak_en_i;
        end
    end

    // peak register update
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            peak_o <= RST_WORD;
        end else if (peak_clr_i) begin
            peak_o <= RST_WORD;
        end else if (peak_en_i && !en_d) begin
            peak_o <= sample_valid_i ? sample_i : current_i;
        end else if (peak_en_i && sample_valid_i) begin
            if (signed_gt(sample_i, peak_o)) begin
                peak_o <= sample_i;
            end
        end
    end

endmodule : arph_peak_track

// ### arph_result_path.sv
// arph_result_path: result registers, display source selection, peak
// and hold, offset calibration and power-down control bits, low
// battery flag. Registers are reached over a deframed host register
// port: one write strobe or read strobe per access.
// assumes conv_valid_i/conv_data_i come from the filter on ref_clk_i,
// cal_done_i comes from the calibration sequencer on ref_clk_i, and
// undervoltage_flag_cmp_i and variant_45_i are pins needing synchronisation.
`timescale 1ns/100ps
module arph_result_path
    import arph_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // host register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // conversion results from the filter
    input wire logic conv_valid_i,
    input wire logic [RAW_W-1:0] conv_data_i,
    // calibration sequencer handshake
    input wire logic cal_done_i,
    // pins
    input wire logic undervoltage_flag_cmp_i,
    input wire logic variant_45_i,
    // controls to the converter and display driver
    output logic [DATA_W-1:0] display_value_o,
    output logic offset_cal_en_o,
    output logic enh_cal_req_o,
    output logic dig_pd_o,
    output logic ana_pd_o,
    output logic range_o,
    output logic undervoltage_flag_seg_o,
    output logic peak_seg_o,
    output logic hold_seg_o
);

    // register contents
    logic [15:0] result_upper_word;
    logic [7:0] result_low_nibble;
    logic [15:0] display_value;
    logic [15:0] peak_value;
    logic [15:0] custom_offset;

    // control bits
    logic src_host;
    logic peak_en;
    logic hold_en;
    logic continuous_offset_disable;
    logic enhanced_offset_trigger;
    logic digital_power_down;
    logic analog_power_down;
    logic range_sel;

    // status and synchronisers
    logic undervoltage_flag;
    logic lb_meta;
    logic lb_sync;
    logic var_meta;
    logic var_sync;

    // decoded accesses and conversion path
    logic wr_control;
    logic wr_display;
    logic wr_offset;
    logic peak_clr;
    logic conv_take;
    logic [RAW_W-1:0] offset_ext;
    logic [RAW_W-1:0] final_result;
    logic [15:0] final_upper;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] control_word;
    logic [DATA_W-1:0] status_word;

    // write decode; read-only indices have no write enable at all
    // read-only writes dropped
    assign wr_control = reg_wr_i && (reg_addr_i == IDX_CONTROL);
    assign wr_display = reg_wr_i && (reg_addr_i == IDX_DISPLAY);
    assign wr_offset = reg_wr_i && (reg_addr_i == IDX_CUSTOM_OFFSET);

    assign peak_clr = wr_control && !reg_wdata_i[CTL_PEAK];

    assign conv_take = conv_valid_i && !digital_power_down;

    // custom offset counts in units of the upper word lsb
    assign offset_ext = {custom_offset, {LOW_W{1'b0}}};

    assign final_result = conv_data_i - offset_ext;
    assign final_upper = final_result[RAW_W-1:LOW_W];

    // pin synchronisers: two flops before any logic reads the level
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lb_meta <= 1'b0;
            lb_sync <= 1'b0;
            var_meta <= 1'b0;
            var_sync <= 1'b0;
        end else begin
            lb_meta <= undervoltage_flag_cmp_i;
            lb_sync <= lb_meta;
            var_meta <= variant_45_i;
            var_sync <= var_meta;
        end
    end

    // undervoltage flag follows the synchronised comparator level
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            undervoltage_flag <= 1'b0;
        end else begin
            undervoltage_flag <= lb_sync;
        end
    end

    // result registers load on every accepted conversion
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_upper_word <= RST_WORD;
            result_low_nibble <= RST_BYTE;
        end else if (conv_take) begin
            // upper bits, layout shared by variants
            result_upper_word <= final_upper;
            result_low_nibble <= {final_result[LOW_W-1:0], {LOW_NIBBLE_POS{1'b0}}};
        end
    end

    // control register fields other than the enhanced trigger
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_host <= 1'b0;
            peak_en <= 1'b0;
            hold_en <= 1'b0;
            continuous_offset_disable <= 1'b0;
            digital_power_down <= 1'b0;
            analog_power_down <= 1'b0;
            range_sel <= 1'b0;
        end else if (wr_control) begin
            src_host <= reg_wdata_i[CTL_SRC_HOST];
            peak_en <= reg_wdata_i[CTL_PEAK];
            hold_en <= reg_wdata_i[CTL_HOLD];
            continuous_offset_disable <= reg_wdata_i[CTL_CONT_OFFSET_DIS];
            digital_power_down <= reg_wdata_i[CTL_DIG_PD];
            analog_power_down <= reg_wdata_i[CTL_ANA_PD];
            range_sel <= reg_wdata_i[CTL_RANGE];
        end
    end

    // enhanced offset trigger: host sets it, the sequencer clears it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enhanced_offset_trigger <= 1'b0;
        end else if (wr_control && reg_wdata_i[CTL_ENH_OFFSET_TRIG]) begin
            enhanced_offset_trigger <= 1'b1;
        end else if (cal_done_i) begin
            enhanced_offset_trigger <= 1'b0;
        end
    end

    // custom offset register, read/write
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            custom_offset <= RST_WORD;
        end else if (wr_offset) begin
            custom_offset <= reg_wdata_i;
        end
    end

    // peak register lives in its own small module
    arph_peak_track u_peak (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .peak_en_i(peak_en),
        .peak_clr_i(peak_clr),
        .sample_valid_i(conv_take),
        .sample_i(final_upper),
        .current_i(result_upper_word),
        .peak_o(peak_value)
    );

    // display register source selection; hold outranks peak, peak
    // outranks the host/result choice
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            display_value <= RST_WORD;
        end else if (hold_en) begin
            display_value <= display_value;
        end else if (digital_power_down) begin
            display_value <= display_value;
        end else if (peak_en) begin
            display_value <= peak_value;
        end else if (src_host) begin
            if (wr_display) begin
                display_value <= reg_wdata_i;
            end
        end else if (conv_take) begin
            display_value <= final_upper;
        end
    end

    // control and status words as read back
    always_comb begin
        control_word = RST_WORD;
        control_word[CTL_SRC_HOST] = src_host;
        control_word[CTL_PEAK] = peak_en;
        control_word[CTL_HOLD] = hold_en;
        control_word[CTL_CONT_OFFSET_DIS] = continuous_offset_disable;
        control_word[CTL_ENH_OFFSET_TRIG] = enhanced_offset_trigger;
        control_word[CTL_DIG_PD] = digital_power_down;
        control_word[CTL_ANA_PD] = analog_power_down;
        control_word[CTL_RANGE] = range_sel;
        status_word = RST_WORD;
        status_word[STS_UNDERVOLTAGE] = undervoltage_flag;
        status_word[STS_PEAK_ACTIVE] = peak_en;
        status_word[STS_HOLD_ACTIVE] = hold_en;
        status_word[STS_ENH_BUSY] = enhanced_offset_trigger;
        status_word[STS_VARIANT_45] = var_sync;
    end

    // read multiplexer; unmapped indices read as zero
    always_comb begin
        unique case (reg_addr_i)
            IDX_RESULT_UPPER: next_rdata = result_upper_word;
            IDX_DISPLAY: next_rdata = display_value;
            IDX_PEAK: next_rdata = peak_value;
            IDX_RESULT_LOW: next_rdata = {RST_BYTE, result_low_nibble};
            IDX_CONTROL: next_rdata = control_word;
            IDX_STATUS: next_rdata = status_word;
            IDX_CUSTOM_OFFSET: next_rdata = custom_offset;
            default: next_rdata = RST_WORD;
        endcase
    end

    // read data is registered and stands until the next read
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= RST_WORD;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // registered controls towards the converter and display driver
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            display_value_o <= RST_WORD;
            offset_cal_en_o <= 1'b0;
            enh_cal_req_o <= 1'b0;
            dig_pd_o <= 1'b0;
            ana_pd_o <= 1'b0;
            range_o <= 1'b0;
            undervoltage_flag_seg_o <= 1'b0;
            peak_seg_o <= 1'b0;
            hold_seg_o <= 1'b0;
        end else begin
            display_value_o <= display_value;
            offset_cal_en_o <= !continuous_offset_disable && !analog_power_down;
            enh_cal_req_o <= enhanced_offset_trigger && !analog_power_down;
            dig_pd_o <= digital_power_down;
            ana_pd_o <= analog_power_down;
            range_o <= range_sel;
            undervoltage_flag_seg_o <= undervoltage_flag && !digital_power_down;
            peak_seg_o <= peak_en && !digital_power_down;
            hold_seg_o <= hold_en && !digital_power_down;
        end
    end

endmodule : arph_result_path

// ### arph_result_monitor.sv
// arph_result_monitor: port-level checks of the result path.
// assumes it is bound into every arph_result_path instance.
`timescale 1ns/100ps
module arph_result_monitor
    import arph_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic conv_valid_i,
    input wire logic [RAW_W-1:0] conv_data_i,
    input wire logic cal_done_i,
    input wire logic undervoltage_flag_cmp_i,
    input wire logic variant_45_i,
    input wire logic [DATA_W-1:0] display_value_o,
    input wire logic offset_cal_en_o,
    input wire logic enh_cal_req_o,
    input wire logic dig_pd_o,
    input wire logic ana_pd_o,
    input wire logic range_o,
    input wire logic undervoltage_flag_seg_o,
    input wire logic peak_seg_o,
    input wire logic hold_seg_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // write to the control register
    sequence ctl_wr;
        reg_wr_i && reg_addr_i == IDX_CONTROL;
    endsequence
    // battery pin low and display powered for six cycles
    sequence batt_low6;
        (undervoltage_flag_cmp_i && !dig_pd_o) [*6];
    endsequence
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    read_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    dig_down_a: assert property (ctl_wr |-> ##2 dig_pd_o == $past(reg_wdata_i[CTL_DIG_PD], 2))
        else $error("digital power-down mismatch");
    ana_down_a: assert property (ctl_wr |-> ##2 ana_pd_o == $past(reg_wdata_i[CTL_ANA_PD], 2))
        else $error("analog power-down mismatch");
    offset_cal_a: assert property (ctl_wr |-> ##2 offset_cal_en_o ==
        !($past(reg_wdata_i[CTL_CONT_OFFSET_DIS], 2) || $past(reg_wdata_i[CTL_ANA_PD], 2)))
        else $error("offset calibration enable mismatch");
    enh_request_a: assert property (ctl_wr ##0 reg_wdata_i[CTL_ENH_OFFSET_TRIG]
        && !reg_wdata_i[CTL_ANA_PD] |-> ##2 enh_cal_req_o)
        else $error("enhanced calibration not requested");
    enh_release_a: assert property (cal_done_i && !(reg_wr_i && reg_addr_i == IDX_CONTROL
        && reg_wdata_i[CTL_ENH_OFFSET_TRIG]) |-> ##2 !enh_cal_req_o)
        else $error("enhanced request not released");
    batt_on_a: assert property (batt_low6 |-> undervoltage_flag_seg_o)
        else $error("low battery segment off");
    batt_off_a: assert property (!undervoltage_flag_cmp_i [*6] |-> !undervoltage_flag_seg_o)
        else $error("low battery segment on");
    hold_freeze_a: assert property ($past(hold_seg_o) |-> $stable(display_value_o))
        else $error("display moved during hold");
endmodule : arph_result_monitor

bind arph_result_path arph_result_monitor u_mon (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
    .cal_done_i(cal_done_i), .undervoltage_flag_cmp_i(undervoltage_flag_cmp_i), .variant_45_i(variant_45_i),
    .display_value_o(display_value_o), .offset_cal_en_o(offset_cal_en_o),
    .enh_cal_req_o(enh_cal_req_o), .dig_pd_o(dig_pd_o), .ana_pd_o(ana_pd_o),
    .range_o(range_o), .undervoltage_flag_seg_o(undervoltage_flag_seg_o), .peak_seg_o(peak_seg_o),
    .hold_seg_o(hold_seg_o)
);

// ### arph_host_model.sv
// arph_host_model: host and filter side of the register port.
// assumes the device samples strobes on the rising clock edge.
`timescale 1ns/100ps
module arph_host_model
    import arph_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [DATA_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [ADDR_W-1:0] reg_addr_o,
    output logic [DATA_W-1:0] reg_wdata_o,
    output logic conv_valid_o,
    output logic [RAW_W-1:0] conv_data_o,
    output logic cal_done_o
);
    // idle levels
    initial begin
        {reg_wr_o, reg_rd_o, conv_valid_o, cal_done_o} = 4'h0;
        {reg_addr_o, reg_wdata_o, conv_data_o} = '0;
    end
    // one-cycle write; released lines show the inverse value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge ref_clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
        @(negedge ref_clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b0, ~a, ~d};
    endtask : wr
    // one-cycle read, answer awaited for a bounded time
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
        output logic ok);
        @(negedge ref_clk_i);
        {reg_rd_o, reg_addr_o} = {1'b1, a};
        @(negedge ref_clk_i);
        {reg_rd_o, reg_addr_o} = {1'b0, ~a};
        ok = 1'b0;
        d = '0;
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            if (reg_rvalid_i === 1'b1) begin
                {ok, d} = {1'b1, reg_rdata_i};
            end else begin
                @(negedge ref_clk_i);
            end
        end
    endtask : rd
    // one conversion result pulse, then a settling cycle
    task automatic conv(input logic [RAW_W-1:0] v);
        @(negedge ref_clk_i);
        {conv_valid_o, conv_data_o} = {1'b1, v};
        @(negedge ref_clk_i);
        {conv_valid_o, conv_data_o} = {1'b0, ~v};
        @(negedge ref_clk_i);
    endtask : conv
    task automatic done();
        @(negedge ref_clk_i);
        cal_done_o = 1'b1;
        @(negedge ref_clk_i);
        cal_done_o = 1'b0;
    endtask : done
endmodule : arph_host_model

// ### tb.sv
// tb: register-level test of the converter result path.
// assumes arph_host_model drives the port; the monitor is bound.
`timescale 1ns/100ps
module tb;
    import arph_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic undervoltage_flag_cmp_i = 1'b0;
    logic variant_45_i = 1'b1;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, conv_valid_i, cal_done_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, display_value_o;
    logic [RAW_W-1:0] conv_data_i;
    logic offset_cal_en_o, enh_cal_req_o, dig_pd_o, ana_pd_o, range_o;
    logic undervoltage_flag_seg_o, peak_seg_o, hold_seg_o;
    int failures = 0;
    int checked = 0;
    logic [15:0] ctl_tab [7] = '{16'h0000, 16'h0008, 16'h0020, 16'h0040, 16'h0090,
        16'h0050, 16'h0000};
    logic [4:0] out_tab [7] = '{5'h02, 5'h00, 5'h0a, 5'h10, 5'h07, 5'h10, 5'h06};

    // 25 MHz clock
    always #20 ref_clk_i = ~ref_clk_i;

    arph_host_model u_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .conv_valid_o(conv_valid_i),
        .conv_data_o(conv_data_i), .cal_done_o(cal_done_i));
    arph_result_path dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .conv_valid_i(conv_valid_i),
        .conv_data_i(conv_data_i), .cal_done_i(cal_done_i), .undervoltage_flag_cmp_i(undervoltage_flag_cmp_i),
        .variant_45_i(variant_45_i), .display_value_o(display_value_o),
        .offset_cal_en_o(offset_cal_en_o), .enh_cal_req_o(enh_cal_req_o),
        .dig_pd_o(dig_pd_o), .ana_pd_o(ana_pd_o), .range_o(range_o),
        .undervoltage_flag_seg_o(undervoltage_flag_seg_o), .peak_seg_o(peak_seg_o), .hold_seg_o(hold_seg_o));

    task automatic finish_test();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // read and compare; a missing answer ends the run
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            failures++;
            finish_test();
        end
        check(d, exp);
    endtask : rdc

    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        @(negedge ref_clk_i) arst_n_i = 1'b1;
        for (int a = 0; a < 16; a++) begin
            if (a != 5) rdc(a[3:0], 16'h0000);
        end
        rdc(IDX_STATUS, 16'h0010);
        u_host.conv(20'h12345);
        rdc(IDX_RESULT_UPPER, 16'h1234);
        rdc(IDX_RESULT_LOW, 16'h0050);
        rdc(IDX_DISPLAY, 16'h1234);
        u_host.wr(IDX_RESULT_UPPER, 16'hffff);
        u_host.wr(IDX_RESULT_LOW, 16'hffff);
        u_host.wr(IDX_PEAK, 16'hffff);
        rdc(IDX_RESULT_UPPER, 16'h1234);
        rdc(IDX_RESULT_LOW, 16'h0050);
        rdc(IDX_PEAK, 16'h0000);
        u_host.wr(IDX_CUSTOM_OFFSET, 16'h0010);
        u_host.conv(20'h12345);
        rdc(IDX_RESULT_UPPER, 16'h1224);
        u_host.wr(IDX_CUSTOM_OFFSET, 16'h0000);
        u_host.wr(IDX_CONTROL, 16'h0001);
        u_host.wr(IDX_DISPLAY, 16'habcd);
        u_host.conv(20'h11110);
        rdc(IDX_DISPLAY, 16'habcd);
        u_host.wr(IDX_CONTROL, 16'h0002);
        rdc(IDX_PEAK, 16'h1111);
        check({15'h0, peak_seg_o}, 16'h0001);
        u_host.conv(20'hff000);
        rdc(IDX_PEAK, 16'h1111);
        u_host.conv(20'h20000);
        rdc(IDX_PEAK, 16'h2000);
        rdc(IDX_DISPLAY, 16'h2000);
        u_host.wr(IDX_CONTROL, 16'h0000);
        rdc(IDX_PEAK, 16'h0000);
        u_host.conv(20'hfe000);
        u_host.wr(IDX_CONTROL, 16'h0002);
        u_host.conv(20'hff000);
        rdc(IDX_PEAK, 16'hff00);
        u_host.wr(IDX_CONTROL, 16'h0000);
        u_host.conv(20'h03000);
        u_host.wr(IDX_CONTROL, 16'h0004);
        u_host.conv(20'h04000);
        rdc(IDX_DISPLAY, 16'h0300);
        check(display_value_o, 16'h0300);
        check({15'h0, hold_seg_o}, 16'h0001);
        rdc(IDX_STATUS, 16'h0014);
        for (int i = 0; i < 7; i++) begin
            u_host.wr(IDX_CONTROL, ctl_tab[i]);
            @(negedge ref_clk_i);
            check({11'h0, ana_pd_o, dig_pd_o, enh_cal_req_o, offset_cal_en_o, range_o},
                {11'h0, out_tab[i]});
        end
        u_host.done();
        @(negedge ref_clk_i);
        check({15'h0, enh_cal_req_o}, 16'h0000);
        undervoltage_flag_cmp_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check({15'h0, undervoltage_flag_seg_o}, 16'h0001);
        rdc(IDX_STATUS, 16'h0011);
        undervoltage_flag_cmp_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        check({15'h0, undervoltage_flag_seg_o}, 16'h0000);
        // strap moves to the 3.5-digit variant; status must follow it
        variant_45_i = 1'b0;
        u_host.wr(IDX_CONTROL, 16'h0020);
        u_host.conv(20'h55555);
        rdc(IDX_RESULT_UPPER, 16'h0400);
        rdc(IDX_STATUS, 16'h0000);
        // mid-run reset returns registers and outputs to defaults
        arst_n_i = 1'b0;
        @(negedge ref_clk_i) arst_n_i = 1'b1;
        check({15'h0, dig_pd_o}, 16'h0000);
        rdc(IDX_RESULT_UPPER, 16'h0000);
        rdc(IDX_CONTROL, 16'h0000);
        finish_test();
    end
endmodule : tb
